// ==== rtl/ist_stats_port.sv ====
`timescale 1ns/10ps
// Function
// - output per-zone high band energy sum
// - output per-zone low band energy sum
// - output four per-zone edge sums
// - output five histogram bins at hist address
// - data valid high only with valid outputs
// - five-bit event vector, fixed bit meanings
// - single rising-edge clock, pixel-synchronous
// - clock enable low freezes everything but sclr_in and rstn_in
// - synchronous clear beats clock enable
// - clear zeroes outputs and internal registers
// - nine parameters held in two copies
// - host copy writable, logic uses working copy
// - commit copies on vblank rise when flagged
// - immediate controls act mid-frame
// - pixel width 8, 10 or 12
// - column and row limits 32 to 4096
// - each histogram kind optional at build
// - all controls and results as ports
// - colour code selects green, red, blue
// - event vector cleared by clear or bit
module ist_stats_port import ist_pkg::*; #(
	parameter int DATA_W   = DATA_W_DEF,
	parameter int MAX_COLS = MAX_COLS_DEF,
	parameter int MAX_ROWS = MAX_ROWS_DEF,
	parameter bit RGB_HIST = 1'b1,
	parameter bit LUMA_HIST = 1'b1,
	parameter bit CHROMA_HIST = 1'b1,
	localparam int COLS_W = $clog2(MAX_COLS),
	localparam int ROWS_W = $clog2(MAX_ROWS),
	localparam int HIST_W = COLS_W + ROWS_W,
	localparam int SUM_W  = DATA_W + COLS_W + ROWS_W,
	localparam int POW_W  = 2 * DATA_W + COLS_W + ROWS_W
) (
	// clock, enable, clears
	input  wire logic                clk_sys_in,
	input  wire logic                rstn_in,
	input  wire logic                ce_in,
	input  wire logic                sclr_in,
	input  wire logic                sw_reset_in,
	// video stream, red high, green mid, blue low
	input  wire logic [3*DATA_W-1:0] video_data_in,
	input  wire logic                vblank_in,
	input  wire logic                hblank_in,
	input  wire logic                active_video_in,
	// double-buffered parameters
	input  wire logic [COLS_W-1:0]   col_boundary_a_in,
	input  wire logic [COLS_W-1:0]   col_boundary_b_in,
	input  wire logic [COLS_W-1:0]   col_boundary_c_in,
	input  wire logic [ROWS_W-1:0]   row_boundary_a_in,
	input  wire logic [ROWS_W-1:0]   row_boundary_b_in,
	input  wire logic [ROWS_W-1:0]   row_boundary_c_in,
	input  wire logic [1:0]          chroma_zoom_in,
	input  wire logic [15:0]         rgb_zone_mask_in,
	input  wire logic [15:0]         ycc_zone_mask_in,
	// immediate controls
	input  wire logic [3:0]          control_in,
	input  wire logic [8:0]          irq_control_in,
	input  wire logic [3:0]          zone_addr_in,
	input  wire logic [1:0]          color_addr_in,
	input  wire logic [DATA_W-1:0]   hist_addr_in,
	input  wire logic                addr_valid_in,
	// per-zone results
	output logic      [POW_W-1:0]    high_band_energy_out,
	output logic      [POW_W-1:0]    low_band_energy_out,
	output logic      [SUM_W-1:0]    edge_horiz_out,
	output logic      [SUM_W-1:0]    edge_vert_out,
	output logic      [SUM_W-1:0]    edge_diag_out,
	output logic      [SUM_W-1:0]    edge_anti_out,
	output logic      [SUM_W-1:0]    chan_sum_out,
	// histogram bins
	output logic      [HIST_W-1:0]   red_hist_out,
	output logic      [HIST_W-1:0]   green_hist_out,
	output logic      [HIST_W-1:0]   blue_hist_out,
	output logic      [HIST_W-1:0]   luma_hist_out,
	output logic      [HIST_W-1:0]   chroma_hist_out,
	// qualifier, events, interrupt
	output logic                     data_valid_out,
	output logic      [EV_W-1:0]     status_out,
	output logic                     irq_out
);
	localparam int BINS = 1 << DATA_W;
	localparam int HALF = DATA_W / 2;
	localparam logic [NUM_BANKS-1:0] BANK_EN = {CHROMA_HIST, LUMA_HIST, RGB_HIST, RGB_HIST,
		RGB_HIST};

	function automatic logic [DATA_W-1:0] absd(input logic [DATA_W-1:0] a,
			input logic [DATA_W-1:0] b);
		absd = (a > b) ? a - b : b - a;
	endfunction : absd

	logic                clr_any;
	logic [DATA_W-1:0]   red, grn, blu, luma, above;
	logic [DATA_W+1:0]   luma_sum;
	logic                vb_rise, vb_fall, hb_rise, line_end, pix_en;
	logic [1:0]          zc, zr;
	logic [3:0]          zone;
	logic [DATA_W-1:0]   d_h, d_v, d_d, d_a, rz, bz;
	logic [2*DATA_W-1:0] sq_y, sq_h;
	logic [EV_W-1:0]     ev_set;

	ist_state_t          state_reg;
	logic                vb_d_reg, hb_d_reg, av_d_reg, ro_d_reg;
	logic [COLS_W-1:0]   wk_ca_reg, wk_cb_reg, wk_cc_reg, act_col_reg;
	logic [ROWS_W-1:0]   wk_ra_reg, wk_rb_reg, wk_rc_reg, act_row_reg;
	logic [1:0]          wk_zoom_reg, frames_reg;
	logic [15:0]         wk_rgbm_reg, wk_yccm_reg;
	logic [COLS_W:0]     tot_col_reg;
	logic [ROWS_W:0]     tot_row_reg;
	logic [DATA_W-1:0]   sweep_reg, y_prev_reg, above_prev_reg, hist_q_reg;
	logic [3:0]          zone_q_reg;
	logic [1:0]          color_q_reg;
	logic [READ_LAT-2:0] rd_pipe_reg;

	logic [DATA_W-1:0]   line_mem [MAX_COLS];
	logic [POW_W-1:0]    hb_acc [NUM_ZONES];
	logic [POW_W-1:0]    lb_acc [NUM_ZONES];
	logic [SUM_W-1:0]    eh_acc [NUM_ZONES];
	logic [SUM_W-1:0]    ev_acc [NUM_ZONES];
	logic [SUM_W-1:0]    ed_acc [NUM_ZONES];
	logic [SUM_W-1:0]    ea_acc [NUM_ZONES];
	logic [SUM_W-1:0]    cs_acc [NUM_ZONES][NUM_CHANS];

	logic [NUM_BANKS-1:0] bank_inc;
	logic [DATA_W-1:0]    bank_addr [NUM_BANKS];
	logic [HIST_W-1:0]    bank_rd [NUM_BANKS];

	// software reset is an input, so it waits for the enable
	assign clr_any = sclr_in | (ce_in & sw_reset_in);

	assign red      = video_data_in[3*DATA_W-1:2*DATA_W];
	assign grn      = video_data_in[2*DATA_W-1:DATA_W];
	assign blu      = video_data_in[DATA_W-1:0];
	assign luma_sum = {2'h0, red} + {1'h0, grn, 1'h0} + {2'h0, blu};
	assign luma     = luma_sum[DATA_W+1:2];
	assign above    = line_mem[act_col_reg];

	assign vb_rise  = vblank_in & ~vb_d_reg;
	assign vb_fall  = ~vblank_in & vb_d_reg;
	assign hb_rise  = hblank_in & ~hb_d_reg;
	assign line_end = av_d_reg & ~active_video_in;
	assign pix_en   = (state_reg == ST_ACQ | (state_reg == ST_WAIT & vb_fall)) &
		active_video_in & control_in[CTL_ENABLE];

	// zone from working boundaries only
	always_comb begin
		zc = (act_col_reg <= wk_ca_reg) ? 2'h0 : (act_col_reg <= wk_cb_reg) ? 2'h1 :
			(act_col_reg <= wk_cc_reg) ? 2'h2 : 2'h3;
		zr = (act_row_reg <= wk_ra_reg) ? 2'h0 : (act_row_reg <= wk_rb_reg) ? 2'h1 :
			(act_row_reg <= wk_rc_reg) ? 2'h2 : 2'h3;
		zone = {zr, zc};
	end

	assign d_h  = absd(luma, y_prev_reg);
	assign d_v  = absd(luma, above);
	assign d_d  = absd(luma, above_prev_reg);
	assign d_a  = absd(y_prev_reg, above);
	assign sq_y = luma * luma;
	assign sq_h = d_h * d_h;
	// zoom magnifies the chroma plane before binning
	assign rz   = DATA_W'(red << wk_zoom_reg);
	assign bz   = DATA_W'(blu << wk_zoom_reg);

	// edge detection and frame timing counters
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vb_d_reg    <= 1'b0;
			hb_d_reg    <= 1'b0;
			av_d_reg    <= 1'b0;
			ro_d_reg    <= 1'b0;
			act_col_reg <= '0;
			act_row_reg <= '0;
			tot_col_reg <= '0;
			tot_row_reg <= '0;
		end else if (clr_any) begin
			vb_d_reg    <= 1'b0;
			hb_d_reg    <= 1'b0;
			av_d_reg    <= 1'b0;
			ro_d_reg    <= 1'b0;
			act_col_reg <= '0;
			act_row_reg <= '0;
			tot_col_reg <= '0;
			tot_row_reg <= '0;
		end else if (ce_in) begin
			vb_d_reg <= vblank_in;
			hb_d_reg <= hblank_in;
			av_d_reg <= active_video_in;
			ro_d_reg <= control_in[CTL_READOUT];
			if (line_end)
				act_col_reg <= '0;
			else if (active_video_in)
				act_col_reg <= act_col_reg + 1'b1;
			if (vb_rise)
				act_row_reg <= '0;
			else if (line_end)
				act_row_reg <= act_row_reg + 1'b1;
			if (hb_rise)
				tot_col_reg <= (COLS_W+1)'(1);
			else if (vb_rise)
				tot_col_reg <= '0;
			else if (~&tot_col_reg)
				tot_col_reg <= tot_col_reg + 1'b1;
			if (vb_rise)
				tot_row_reg <= '0;
			else if (hb_rise && ~&tot_row_reg)
				tot_row_reg <= tot_row_reg + 1'b1;
		end
	end

	// working copies of double-buffered parameters
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			{wk_ca_reg, wk_cb_reg, wk_cc_reg} <= '0;
			{wk_ra_reg, wk_rb_reg, wk_rc_reg} <= '0;
			{wk_zoom_reg, wk_rgbm_reg, wk_yccm_reg} <= '0;
		end else if (clr_any) begin
			{wk_ca_reg, wk_cb_reg, wk_cc_reg} <= '0;
			{wk_ra_reg, wk_rb_reg, wk_rc_reg} <= '0;
			{wk_zoom_reg, wk_rgbm_reg, wk_yccm_reg} <= '0;
		end else if (ce_in && vb_rise && control_in[CTL_COMMIT]) begin
			wk_ca_reg   <= col_boundary_a_in;
			wk_cb_reg   <= col_boundary_b_in;
			wk_cc_reg   <= col_boundary_c_in;
			wk_ra_reg   <= row_boundary_a_in;
			wk_rb_reg   <= row_boundary_b_in;
			wk_rc_reg   <= row_boundary_c_in;
			wk_zoom_reg <= chroma_zoom_in;
			wk_rgbm_reg <= rgb_zone_mask_in;
			wk_yccm_reg <= ycc_zone_mask_in;
		end
	end

	// acquisition sequencing and ram sweep
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= ST_INIT;
			sweep_reg <= '0;
		end else if (clr_any) begin
			state_reg <= ST_INIT;
			sweep_reg <= '0;
		end else if (ce_in) begin
			case (state_reg)
				ST_INIT: begin
					sweep_reg <= sweep_reg + 1'b1;
					if (sweep_reg == DATA_W'(BINS - 1))
						state_reg <= ST_WAIT;
				end
				ST_WAIT: begin
					if (vb_fall && control_in[CTL_ENABLE])
						state_reg <= ST_ACQ;
				end
				ST_ACQ: begin
					if (vb_rise)
						state_reg <= ST_READ;
				end
				ST_READ: begin
					// leaving readout wipes the stores for the next frame
					if (ro_d_reg && !control_in[CTL_READOUT])
						state_reg <= ST_INIT;
				end
				default: state_reg <= ST_INIT;
			endcase
		end
	end

	// pixel neighbourhood and per-zone accumulators, ram-like, no reset
	always_ff @(posedge clk_sys_in) begin
		if (ce_in) begin
			if (state_reg == ST_INIT) begin
				if (sweep_reg < DATA_W'(NUM_ZONES)) begin
					hb_acc[sweep_reg[3:0]] <= '0;
					lb_acc[sweep_reg[3:0]] <= '0;
					eh_acc[sweep_reg[3:0]] <= '0;
					ev_acc[sweep_reg[3:0]] <= '0;
					ed_acc[sweep_reg[3:0]] <= '0;
					ea_acc[sweep_reg[3:0]] <= '0;
					for (int k = 0; k < NUM_CHANS; k++)
						cs_acc[sweep_reg[3:0]][k] <= '0;
				end
			end else if (pix_en) begin
				line_mem[act_col_reg] <= luma;
				hb_acc[zone] <= hb_acc[zone] + POW_W'(sq_h);
				lb_acc[zone] <= lb_acc[zone] + POW_W'(sq_y);
				eh_acc[zone] <= eh_acc[zone] + SUM_W'(d_h);
				ev_acc[zone] <= ev_acc[zone] + SUM_W'(d_v);
				ed_acc[zone] <= ed_acc[zone] + SUM_W'(d_d);
				ea_acc[zone] <= ea_acc[zone] + SUM_W'(d_a);
				cs_acc[zone][CHAN_GREEN] <= cs_acc[zone][CHAN_GREEN] + SUM_W'(grn);
				cs_acc[zone][CHAN_RED]   <= cs_acc[zone][CHAN_RED] + SUM_W'(red);
				cs_acc[zone][CHAN_BLUE]  <= cs_acc[zone][CHAN_BLUE] + SUM_W'(blu);
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			y_prev_reg     <= '0;
			above_prev_reg <= '0;
		end else if (clr_any || (ce_in && line_end)) begin
			y_prev_reg     <= '0;
			above_prev_reg <= '0;
		end else if (ce_in && pix_en) begin
			y_prev_reg     <= luma;
			above_prev_reg <= above;
		end
	end

	// histogram banks
	always_comb begin
		bank_inc = {pix_en & wk_yccm_reg[zone], pix_en & wk_yccm_reg[zone],
			{3{pix_en & wk_rgbm_reg[zone]}}};
		bank_addr[BANK_RED]    = red;
		bank_addr[BANK_GREEN]  = grn;
		bank_addr[BANK_BLUE]   = blu;
		bank_addr[BANK_LUMA]   = luma;
		bank_addr[BANK_CHROMA] = {rz[DATA_W-1 -: HALF], bz[DATA_W-1 -: DATA_W-HALF]};
	end

	for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
		if (BANK_EN[i]) begin : g_on
			ist_hist_bank #(.ADDR_W(DATA_W), .CNT_W(HIST_W)) u_bank (
				.clk_sys_in  (clk_sys_in),
				.rstn_in     (rstn_in),
				.ce_in       (ce_in),
				.clr_in      (clr_any),
				.wipe_in     (state_reg == ST_INIT),
				.wipe_addr_in(sweep_reg),
				.inc_in      (bank_inc[i]),
				.inc_addr_in (bank_addr[i]),
				.rd_addr_in  (hist_q_reg),
				.rd_data_out (bank_rd[i])
			);
		end else begin : g_off
			assign bank_rd[i] = '0;
		end
	end

	// events, set beats clear
	always_comb begin
		ev_set = EVENT_RST;
		ev_set[EV_VSYNC]   = vb_fall;
		ev_set[EV_DONE]    = (state_reg == ST_ACQ) & vb_rise;
		ev_set[EV_ROW_ERR] = vb_rise & (tot_row_reg > (ROWS_W+1)'(MAX_ROWS));
		ev_set[EV_COL_ERR] = hb_rise & (tot_col_reg > (COLS_W+1)'(MAX_COLS));
		ev_set[EV_SETTLED] = ev_set[EV_DONE] & (frames_reg == 2'(SETTLE_FRAMES - 1));
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_out <= EVENT_RST;
			frames_reg <= '0;
			irq_out    <= 1'b0;
		end else if (clr_any) begin
			status_out <= EVENT_RST;
			frames_reg <= '0;
			irq_out    <= 1'b0;
		end else if (ce_in) begin
			status_out <= (control_in[CTL_EVCLR] ? EVENT_RST : status_out) | ev_set;
			if (ev_set[EV_DONE] && frames_reg != 2'h3)
				frames_reg <= frames_reg + 1'b1;
			irq_out <= irq_control_in[IRQ_GIE] &
				|(status_out[EV_COL_ERR:EV_VSYNC] & irq_control_in[3:0]);
		end
	end

	// readout: sample addresses, wait for bank reads, then present
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			zone_q_reg     <= '0;
			color_q_reg    <= '0;
			hist_q_reg     <= '0;
			rd_pipe_reg    <= '0;
			data_valid_out <= 1'b0;
		end else if (clr_any) begin
			zone_q_reg     <= '0;
			color_q_reg    <= '0;
			hist_q_reg     <= '0;
			rd_pipe_reg    <= '0;
			data_valid_out <= 1'b0;
		end else if (ce_in) begin
			if (state_reg != ST_READ || !addr_valid_in) begin
				rd_pipe_reg    <= '0;
				data_valid_out <= 1'b0;
			end else begin
				if (rd_pipe_reg == '0 && !data_valid_out) begin
					zone_q_reg  <= zone_addr_in;
					color_q_reg <= color_addr_in;
					hist_q_reg  <= hist_addr_in;
				end
				rd_pipe_reg <= {rd_pipe_reg[READ_LAT-3:0], ~|rd_pipe_reg & ~data_valid_out};
				if (rd_pipe_reg[READ_LAT-2])
					data_valid_out <= 1'b1;
			end
		end
	end

	// result registers load once per request and hold while valid
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			{high_band_energy_out, low_band_energy_out} <= '0;
			{edge_horiz_out, edge_vert_out, edge_diag_out, edge_anti_out} <= '0;
			chan_sum_out <= '0;
			{red_hist_out, green_hist_out, blue_hist_out} <= '0;
			{luma_hist_out, chroma_hist_out} <= '0;
		end else if (clr_any) begin
			{high_band_energy_out, low_band_energy_out} <= '0;
			{edge_horiz_out, edge_vert_out, edge_diag_out, edge_anti_out} <= '0;
			chan_sum_out <= '0;
			{red_hist_out, green_hist_out, blue_hist_out} <= '0;
			{luma_hist_out, chroma_hist_out} <= '0;
		end else if (ce_in && state_reg == ST_READ && addr_valid_in &&
				rd_pipe_reg[READ_LAT-2]) begin
			high_band_energy_out <= hb_acc[zone_q_reg];
			low_band_energy_out  <= lb_acc[zone_q_reg];
			edge_horiz_out       <= eh_acc[zone_q_reg];
			edge_vert_out        <= ev_acc[zone_q_reg];
			edge_diag_out        <= ed_acc[zone_q_reg];
			edge_anti_out        <= ea_acc[zone_q_reg];
			chan_sum_out <= (color_q_reg > CHAN_BLUE) ? '0 : cs_acc[zone_q_reg][color_q_reg];
			red_hist_out         <= bank_rd[BANK_RED];
			green_hist_out       <= bank_rd[BANK_GREEN];
			blue_hist_out        <= bank_rd[BANK_BLUE];
			luma_hist_out        <= bank_rd[BANK_LUMA];
			chroma_hist_out      <= bank_rd[BANK_CHROMA];
		end
	end
endmodule : ist_stats_port

// ==== rtl/ist_pkg.sv ====
package ist_pkg;
	// build defaults
	localparam int DATA_W_DEF   = 8;
	localparam int MAX_COLS_DEF = 1023;
	localparam int MAX_ROWS_DEF = 1023;
	localparam int NUM_ZONES    = 16;
	localparam int NUM_CHANS    = 3;
	localparam int NUM_BANKS    = 5;

	// control vector bit positions
	localparam int CTL_ENABLE  = 0;
	localparam int CTL_COMMIT  = 1;
	localparam int CTL_READOUT = 2;
	localparam int CTL_EVCLR   = 3;

	// event vector bit positions
	localparam int EV_VSYNC   = 0;
	localparam int EV_DONE    = 1;
	localparam int EV_ROW_ERR = 2;
	localparam int EV_COL_ERR = 3;
	localparam int EV_SETTLED = 4;
	localparam int EV_W       = 5;
	localparam int IRQ_GIE    = 8;
	localparam logic [EV_W-1:0] EVENT_RST = 5'h00;

	// frames completed before timing counts are trusted
	localparam int SETTLE_FRAMES = 2;
	// cycles from sampled addr_valid to data_valid high
	localparam int READ_LAT = 3;

	// colour channel codes
	localparam logic [1:0] CHAN_GREEN = 2'h0;
	localparam logic [1:0] CHAN_RED   = 2'h1;
	localparam logic [1:0] CHAN_BLUE  = 2'h2;

	// histogram bank order
	localparam int BANK_RED    = 0;
	localparam int BANK_GREEN  = 1;
	localparam int BANK_BLUE   = 2;
	localparam int BANK_LUMA   = 3;
	localparam int BANK_CHROMA = 4;

	typedef enum logic [3:0] {
		ST_INIT = 4'h1,
		ST_WAIT = 4'h2,
		ST_ACQ  = 4'h4,
		ST_READ = 4'h8
	} ist_state_t;
endpackage : ist_pkg

// ==== rtl/ist_hist_bank.sv ====
`timescale 1ns/10ps
module ist_hist_bank import ist_pkg::*; #(
	parameter int ADDR_W = DATA_W_DEF,
	parameter int CNT_W  = 20
) (
	// clock and control
	input  wire logic              clk_sys_in,
	input  wire logic              rstn_in,
	input  wire logic              ce_in,
	input  wire logic              clr_in,
	// sweep clear and bin increment
	input  wire logic              wipe_in,
	input  wire logic [ADDR_W-1:0] wipe_addr_in,
	input  wire logic              inc_in,
	input  wire logic [ADDR_W-1:0] inc_addr_in,
	// readout
	input  wire logic [ADDR_W-1:0] rd_addr_in,
	output logic      [CNT_W-1:0]  rd_data_out
);
	logic [CNT_W-1:0] bin_mem [1<<ADDR_W];

	// ram has no reset; the init sweep zeroes it
	always_ff @(posedge clk_sys_in) begin
		if (ce_in) begin
			if (wipe_in)
				bin_mem[wipe_addr_in] <= '0;
			else if (inc_in)
				bin_mem[inc_addr_in] <= bin_mem[inc_addr_in] + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			rd_data_out <= '0;
		else if (clr_in)
			rd_data_out <= '0;
		else if (ce_in)
			rd_data_out <= bin_mem[rd_addr_in];
	end
endmodule : ist_hist_bank

// ==== tb/ist_port_chk_asserts.sv ====
`timescale 1ns/10ps
module ist_port_chk import ist_pkg::*; #(
	parameter int DATA_W   = DATA_W_DEF,
	parameter int MAX_COLS = MAX_COLS_DEF,
	parameter int MAX_ROWS = MAX_ROWS_DEF,
	localparam int HIST_W  = $clog2(MAX_COLS) + $clog2(MAX_ROWS)
) (
	// clock and controls
	input wire logic                     clk_sys_in,
	input wire logic                     rstn_in,
	input wire logic                     ce_in,
	input wire logic                     sclr_in,
	input wire logic                     sw_reset_in,
	input wire logic                     vblank_in,
	input wire logic                     hblank_in,
	input wire logic [3:0]               control_in,
	input wire logic [8:0]               irq_control_in,
	input wire logic [1:0]               color_addr_in,
	input wire logic                     addr_valid_in,
	// watched results
	input wire logic [DATA_W+HIST_W-1:0] chan_sum_out,
	input wire logic [HIST_W-1:0]        red_hist_out,
	input wire logic                     data_valid_out,
	input wire logic [EV_W-1:0]          status_out,
	input wire logic                     irq_out
);
	wire logic quiet   = ce_in && !sclr_in && !sw_reset_in;
	wire logic irq_due = irq_control_in[IRQ_GIE] && |(status_out[3:0] & irq_control_in[3:0]);
	default clocking dcb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rstn_in);
	sequence s_held_valid;
		data_valid_out ##1 data_valid_out;
	endsequence
	sequence s_held_clear;
		(ce_in && control_in[CTL_EVCLR] && !hblank_in && $stable(vblank_in)) [*4];
	endsequence
	sequence s_vsync_seen;
		quiet && $fell(vblank_in) ##1 quiet;
	endsequence
	AST_VALID_HOLD: assert property (s_held_valid |-> $stable(red_hist_out) && $stable(chan_sum_out))
		else $error("results moved while valid");
	AST_VALID_RISE: assert property ($rose(data_valid_out) |-> $past(addr_valid_in, 1) &&
		$past(addr_valid_in, 2) && $past(addr_valid_in, 3)) else $error("valid without request");
	AST_VALID_DROP: assert property (data_valid_out && quiet && !addr_valid_in |=> !data_valid_out)
		else $error("valid kept after address drop");
	AST_FREEZE: assert property (!ce_in && !sclr_in |=> $stable(status_out) &&
		$stable(data_valid_out) && $stable(irq_out) && $stable(red_hist_out)) else $error("moved with ce low");
	AST_SCLR: assert property (sclr_in |=> status_out == EVENT_RST && !data_valid_out && !irq_out &&
		red_hist_out == '0 && chan_sum_out == '0) else $error("clear left outputs set");
	AST_IRQ_SET: assert property (quiet && irq_due |=> irq_out)
		else $error("interrupt missing");
	AST_IRQ_CLR: assert property (quiet && !irq_due |=> !irq_out)
		else $error("interrupt without enabled event");
	AST_STICKY: assert property (quiet && !control_in[CTL_EVCLR] |=>
		(status_out & $past(status_out)) == $past(status_out)) else $error("event bit dropped");
	AST_EVCLR: assert property (s_held_clear |-> status_out == EVENT_RST)
		else $error("events not cleared");
	AST_VSYNC: assert property (s_vsync_seen |-> ##[0:1] status_out[EV_VSYNC])
		else $error("blanking fall not flagged");
	AST_CHAN3: assert property ($rose(data_valid_out) && addr_valid_in && color_addr_in == 2'h3
		|-> chan_sum_out == '0) else $error("unused colour code gave data");
endmodule : ist_port_chk

bind ist_stats_port ist_port_chk #(.DATA_W(DATA_W), .MAX_COLS(MAX_COLS), .MAX_ROWS(MAX_ROWS)) chk_u (
	.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in), .sclr_in(sclr_in),
	.sw_reset_in(sw_reset_in), .vblank_in(vblank_in), .hblank_in(hblank_in),
	.control_in(control_in), .irq_control_in(irq_control_in), .color_addr_in(color_addr_in),
	.addr_valid_in(addr_valid_in), .chan_sum_out(chan_sum_out), .red_hist_out(red_hist_out),
	.data_valid_out(data_valid_out), .status_out(status_out), .irq_out(irq_out)
);

// ==== tb/ist_vid_src.sv ====
`timescale 1ns/10ps
module ist_vid_src import ist_pkg::*; #(
	parameter int DATA_W = DATA_W_DEF
) (
	// clock and frame request
	input  wire logic                clk_sys_in,
	input  wire logic                ce_in,
	input  wire logic                go_in,
	input  wire logic [7:0]          cols_in,
	input  wire logic [7:0]          rows_in,
	input  wire logic [3*DATA_W-1:0] seed_in,
	output logic                     busy_out,
	// video stream
	output logic      [3*DATA_W-1:0] video_data_out,
	output logic                     vblank_out,
	output logic                     hblank_out,
	output logic                     active_out
);
	logic [3*DATA_W-1:0] pix;
	// pixel clock steps only with ce, same as the block
	task automatic tick();
		do @(posedge clk_sys_in); while (ce_in !== 1'b1);
		#1;
	endtask : tick
	initial begin
		{vblank_out, hblank_out, active_out, busy_out} = 4'h0;
		video_data_out = '0;
		forever begin
			tick();
			if (go_in) begin
				busy_out = 1'b1;
				pix = seed_in;
				for (int ln = 0; ln < rows_in + 4; ln++) begin
					// rise opens the frame, fall starts lines, rise closes it
					vblank_out = (ln < 2) || (ln >= rows_in + 2);
					for (int c = 0; c < cols_in; c++) begin
						hblank_out = (c >= cols_in - 8);
						active_out = !vblank_out && !hblank_out;
						pix = pix * 5 + 1;
						// data outside active video is not held
						video_data_out = active_out ? pix : ~video_data_out;
						tick();
					end
				end
				{vblank_out, hblank_out, active_out} = 3'h0;
				repeat (4) tick();
				busy_out = 1'b0;
			end
		end
	end
endmodule : ist_vid_src

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb import ist_pkg::*;;
	logic        clk_sys_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        ce_in = 1'b1;
	logic        sclr_in = 1'b0;
	logic        addr_valid_in = 1'b0;
	logic        go = 1'b0;
	logic        cnt_en = 1'b0;
	logic [4:0]  bnd_a = 5'h01;
	logic [4:0]  bnd_b = 5'h08;
	logic [1:0]  zoom = 2'h0;
	logic [15:0] mask = 16'hffff;
	logic [3:0]  control_in = 4'h0;
	logic [8:0]  irq_ctl = 9'h000;
	logic [3:0]  zone = 4'h0;
	logic [1:0]  color = 2'h0;
	logic [7:0]  haddr = 8'h00;
	logic [7:0]  f_cols = 8'h18;
	logic [7:0]  f_rows = 8'h14;
	logic [7:0]  first_r = 8'h00;
	logic [23:0] seed = 24'h000001;
	logic [23:0] vdata;
	logic        vblank, hblank, active, busy, data_valid_out, irq_out;
	logic [9:0]  red_h, green_h, blue_h;
	logic [4:0]  status_out;
	int          hr[256], hg[256], hb[256];
	int          n_done = 0;
	int          n_mismatch = 0;
	int          n_compared = 0;

	always #20 clk_sys_in = ~clk_sys_in;

	ist_vid_src src_u (.clk_sys_in(clk_sys_in), .ce_in(ce_in), .go_in(go), .cols_in(f_cols),
		.rows_in(f_rows), .seed_in(seed), .busy_out(busy), .video_data_out(vdata),
		.vblank_out(vblank), .hblank_out(hblank), .active_out(active));

	ist_stats_port #(.MAX_COLS(32), .MAX_ROWS(32)) dut_u (.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in), .ce_in(ce_in), .sclr_in(sclr_in), .sw_reset_in(1'b0),
		.video_data_in(vdata), .vblank_in(vblank), .hblank_in(hblank), .active_video_in(active),
		.col_boundary_a_in(bnd_a), .col_boundary_b_in(bnd_b), .col_boundary_c_in(5'h1f),
		.row_boundary_a_in(bnd_a), .row_boundary_b_in(bnd_b), .row_boundary_c_in(5'h1f),
		.chroma_zoom_in(zoom), .rgb_zone_mask_in(mask), .ycc_zone_mask_in(mask),
		.control_in(control_in), .irq_control_in(irq_ctl), .zone_addr_in(zone),
		.color_addr_in(color), .hist_addr_in(haddr), .addr_valid_in(addr_valid_in),
		.high_band_energy_out(), .low_band_energy_out(), .edge_horiz_out(), .edge_vert_out(),
		.edge_diag_out(), .edge_anti_out(), .chan_sum_out(), .red_hist_out(red_h),
		.green_hist_out(green_h), .blue_hist_out(blue_h), .luma_hist_out(),
		.chroma_hist_out(), .data_valid_out(data_valid_out), .status_out(status_out),
		.irq_out(irq_out));

	// reference histograms
	always @(posedge clk_sys_in) begin
		if (cnt_en && ce_in && active) begin
			if (hr.sum() == 0) first_r = vdata[23:16];
			hr[vdata[23:16]]++;
			hg[vdata[15:8]]++;
			hb[vdata[7:0]]++;
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : cyc

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// leave readout, then let the store sweep finish
	task automatic restart(input logic [3:0] ctl);
		control_in = ctl | 4'h4;
		cyc(1);
		control_in = ctl;
		hr = '{default: 0};
		hg = '{default: 0};
		hb = '{default: 0};
		cyc(300);
	endtask : restart

	task automatic frame(input logic [7:0] cols, input logic [7:0] rows);
		int n;
		f_cols = cols;
		f_rows = rows;
		seed = 24'($urandom);
		go = 1'b1;
		n = 0;
		do begin cyc(1); n++; end while (busy !== 1'b1 && n < 10);
		go = 1'b0;
		do begin cyc(1); n++; end while (busy !== 1'b0 && n < 5000);
		n_done++;
		check("events", {n_done >= 2, 3'h0, 1'b1} | 5'h02, status_out & 5'h13);
	endtask : frame

	task automatic rd(input logic [7:0] a, input logic [1:0] c);
		int n;
		haddr = a;
		color = c;
		zone = 4'($urandom);
		addr_valid_in = 1'b1;
		n = 0;
		do begin cyc(1); n++; end while (data_valid_out !== 1'b1 && n < 10);
		check("latency", READ_LAT, n);
		check("red bin", hr[a], 32'(red_h));
		check("green bin", hg[a], 32'(green_h));
		check("blue bin", hb[a], 32'(blue_h));
		cyc(1);
		addr_valid_in = 1'b0;
		cyc(2);
		check("valid drop", 0, 32'(data_valid_out));
	endtask : rd

	task automatic read_bank();
		for (int k = 0; k < 8; k++) rd((k == 0) ? first_r : 8'($urandom), 2'(k));
	endtask : read_bank

	initial begin
		repeat (40000) @(posedge clk_sys_in);
		n_mismatch++;
		$display("BAD watchdog expected end seen timeout");
		tally_and_finish();
	end

	initial begin
		void'($urandom(62815));
		bnd_a = 5'($urandom_range(4, 1));
		bnd_b = bnd_a + 5'h06;
		zoom = 2'($urandom);
		cyc(16);
		rstn_in = 1'b1;
		check("reset outs", 0, {status_out, data_valid_out, irq_out, red_h});
		irq_ctl = 9'h101;
		restart(4'h3);
		cnt_en = 1'b1;
		frame(8'd24, 8'd20);
		cnt_en = 1'b0;
		check("irq on", 1, 32'(irq_out));
		read_bank();
		control_in[CTL_EVCLR] = 1'b1;
		cyc(6);
		control_in[CTL_EVCLR] = 1'b0;
		cyc(2);
		check("cleared", 0, {status_out, irq_out});
		ce_in = 1'b0;
		addr_valid_in = 1'b1;
		cyc(8);
		check("frozen", 0, {status_out, data_valid_out});
		addr_valid_in = 1'b0;
		ce_in = 1'b1;
		mask = 16'h0000;
		irq_ctl = 9'h00f;
		restart(4'h1);
		cnt_en = 1'b1;
		frame(8'd24, 8'd20);
		cnt_en = 1'b0;
		check("irq gated", 0, 32'(irq_out));
		read_bank();
		restart(4'h3);
		frame(8'd24, 8'd20);
		read_bank();
		restart(4'h3);
		frame(8'd40, 8'd36);
		check("framing errs", 2'h3, 32'(status_out[3:2]));
		ce_in = 1'b0;
		sclr_in = 1'b1;
		cyc(1);
		sclr_in = 1'b0;
		check("sclr", 0, {status_out, data_valid_out, irq_out, red_h});
		ce_in = 1'b1;
		tally_and_finish();
	end
endmodule : tb
